// ===== dwell_if.sv
`timescale 1ns/1ps
// Carries a dwell load request and the expiry back from the dwell timer.
interface dwell_if;
	import list_seq_pkg::*;
	logic               load;   // Reload the counter with value.
	logic               stop;   // Cancel the running interval.
	logic [DWELL_W-1:0] value;  // Interval in ticks.
	logic               expire; // One-cycle pulse at interval end.
	modport ctrl  (output load, output stop, output value, input expire);
	modport timer (input load, input stop, input value, output expire);
endinterface

// ===== dwell_timer.sv
`timescale 1ns/1ps
// Counts dwell intervals in units of a fixed internal tick.
module dwell_timer
	import list_seq_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic reset,
	dwell_if.timer    dw
);
	logic [TICK_W-1:0]  tick_r;    // Prescaler toward one tick.
	logic [TICK_W-1:0]  tick_nxt;
	logic [DWELL_W-1:0] left_r;    // Ticks left in the interval.
	logic [DWELL_W-1:0] left_nxt;
	logic               run_r;     // Interval in progress.
	logic               run_nxt;
	logic               exp_r;     // Registered expiry pulse.
	logic               exp_nxt;

	// The prescaler restarts on load so every interval is a whole number of ticks.
	always_comb begin
		tick_nxt = tick_r;
		left_nxt = left_r;
		run_nxt  = run_r;
		exp_nxt  = 1'b0;
		if (dw.stop) begin
			run_nxt = 1'b0;
		end else if (dw.load) begin
			tick_nxt = '0;
			left_nxt = dw.value;
			run_nxt  = 1'b1;
		end else if (run_r) begin
			if (left_r == '0) begin
				// A zero dwell still takes one cycle to report.
				run_nxt = 1'b0;
				exp_nxt = 1'b1;
			end else if (tick_r == TICK_W'(TICK_CYCLES - 1)) begin
				tick_nxt = '0;
				left_nxt = left_r - DWELL_W'(1);
			end else begin
				tick_nxt = tick_r + TICK_W'(1);
			end
		end
	end

	// Registers only.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tick_r <= '0;
			left_r <= '0;
			run_r  <= 1'b0;
			exp_r  <= 1'b0;
		end else begin
			tick_r <= tick_nxt;
			left_r <= left_nxt;
			run_r  <= run_nxt;
			exp_r  <= exp_nxt;
		end
	end

	assign dw.expire = exp_r;
endmodule // dwell_timer

// ===== list_cmd_host.sv
`timescale 1ns/1ps
// Controller model: issues one command at a time on the strobe interface.
module list_cmd_host
	import list_seq_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               cmd_ready,
	output logic                    cmd_valid,
	output logic [3:0]              cmd_code,
	output logic [POINT_IDX_W-1:0]  cmd_index,
	output logic [DWELL_W-1:0]      cmd_data,
	output logic [POINT_IDX_W-1:0]  cmd_len,
	output logic                    cmd_inf
);
	// Quiet bus at time zero.
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 4'h0;
		cmd_index = 5'h00;
		cmd_data = 32'h00000000;
		cmd_len = 5'h01;
		cmd_inf = 1'b0;
	end
	// Called just after a rising edge; holds everything until ready is seen.
	task send(input cmd_t c, input logic [4:0] i, input logic [31:0] d,
		input logic [4:0] l, input logic f);
		begin
			cmd_code <= c;
			cmd_index <= i;
			cmd_data <= d;
			cmd_len <= l;
			cmd_inf <= f;
			cmd_valid <= 1'b1;
			@(posedge sys_clk);
			while (cmd_ready !== 1'b1) begin
				@(posedge sys_clk);
			end
			// Released data flips so a stale value is never mistaken for fresh.
			cmd_valid <= 1'b0;
			cmd_data <= ~d;
			@(posedge sys_clk);
		end
	endtask
endmodule // list_cmd_host

// ===== list_seq_pkg.sv
package list_seq_pkg;

	// Storage geometry.
	localparam int MAX_POINTS      = 20;
	localparam int POINT_IDX_W     = 5;
	localparam int LEVEL_W         = 16;
	localparam int DWELL_W         = 32;
	localparam int COUNT_W         = 16;

	// Clock rate and the dwell tick; dwell values count ticks of this period.
	localparam int CLK_PERIOD_NS   = 5;
	localparam int TICK_PERIOD_US  = 1;
	localparam int TICK_CYCLES     = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
	localparam int TICK_W          = 8;

	// Values after reset.
	localparam logic [COUNT_W-1:0] REPEAT_RESET = 16'h0001;
	localparam logic [POINT_IDX_W-1:0] LEN_RESET = 5'h01;

	// Command codes presented on cmd_code with a cmd_valid strobe.
	typedef enum logic [3:0] {
		CMD_NONE     = 4'h0,
		CMD_INIT     = 4'h1,
		CMD_TRIGGER  = 4'h2,
		CMD_ABORT    = 4'h3,
		CMD_RESET    = 4'h4,
		CMD_RECALL   = 4'h5,
		CMD_SAVE     = 4'h6,
		CMD_LIST_V   = 4'h7,
		CMD_LIST_I   = 4'h8,
		CMD_LIST_DW  = 4'h9,
		CMD_COUNT    = 4'hA,
		CMD_WAIT     = 4'hB,
		CMD_OPC      = 4'hC,
		CMD_OPC_Q    = 4'hD,
		CMD_LEVEL_V  = 4'hE,
		CMD_LEVEL_I  = 4'hF
	} cmd_t;

	// Trigger logic states, one-hot.
	typedef enum logic [3:0] {
		TS_IDLE      = 4'b0001,
		TS_ARMED     = 4'b0010,
		TS_CHANGE    = 4'b0100,
		TS_DWELL     = 4'b1000
	} trig_state_t;

endpackage

// ===== output_list_sequencer.sv
`timescale 1ns/1ps
module output_list_sequencer
	import list_seq_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	input  wire logic                   cmd_valid,
	output logic                        cmd_ready,
	input  wire logic [3:0]             cmd_code,
	input  wire logic [POINT_IDX_W-1:0] cmd_index,
	input  wire logic [DWELL_W-1:0]     cmd_data,
	input  wire logic [POINT_IDX_W-1:0] cmd_len,
	input  wire logic                   cmd_inf,
	input  wire logic                   volt_list_mode,
	input  wire logic                   curr_list_mode,
	input  wire logic                   step_once,
	input  wire logic                   ext_trigger,
	input  wire logic                   other_pending,
	input  wire logic [LEVEL_W-1:0]     volt_fixed,
	input  wire logic [LEVEL_W-1:0]     curr_fixed,
	output logic [LEVEL_W-1:0]          volt_out,
	output logic [LEVEL_W-1:0]          curr_out,
	output logic                        dwelling_flag,
	output logic                        sequence_done_event,
	output logic                        opc_status,
	output logic                        opc_query_valid,
	output logic [7:0]                  opc_query_data,
	output logic [COUNT_W-1:0]          repeat_count,
	output logic                        repeat_inf
);
	////////////////////////////////////////////////////////////////////////////
	// Point storage.
	////////////////////////////////////////////////////////////////////////////

	logic [LEVEL_W-1:0] vpt_r [MAX_POINTS];   // Voltage points.
	logic [LEVEL_W-1:0] ipt_r [MAX_POINTS];   // Current points.
	logic [DWELL_W-1:0] dpt_r [MAX_POINTS];   // Dwell points in ticks.
	logic [POINT_IDX_W-1:0] vlen_r;           // Voltage list length.
	logic [POINT_IDX_W-1:0] ilen_r;           // Current list length.
	logic [POINT_IDX_W-1:0] dlen_r;           // Dwell list length.
	logic [COUNT_W-1:0] rpt_r;                // Repeat count.
	logic [COUNT_W-1:0] rpt_nxt;
	logic               inf_r;                // Repeat forever.
	logic               inf_nxt;
	logic [COUNT_W-1:0] rpt_saved_r;          // Saved setup copy.
	logic               inf_saved_r;

	logic cmd_take;                           // Command accepted this cycle.
	assign cmd_take = cmd_valid && cmd_ready;

	// Returns the entry to use at idx: a one-entry list repeats its only value.
	function automatic logic [POINT_IDX_W-1:0] pick(
		input logic [POINT_IDX_W-1:0] len,
		input logic [POINT_IDX_W-1:0] idx
	);
		pick = (len == POINT_IDX_W'(1)) ? '0 : idx;
	endfunction

	// Each slot is written by its own list command at its index.
	generate
		for (genvar g = 0; g < MAX_POINTS; g++) begin : g_pts
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					vpt_r[g] <= '0;
					ipt_r[g] <= '0;
					dpt_r[g] <= '0;
				end else if (cmd_take && cmd_index == POINT_IDX_W'(g)) begin
					if (cmd_code == CMD_LIST_V) begin
						vpt_r[g] <= cmd_data[LEVEL_W-1:0];
					end
					if (cmd_code == CMD_LIST_I) begin
						ipt_r[g] <= cmd_data[LEVEL_W-1:0];
					end
					if (cmd_code == CMD_LIST_DW) begin
						dpt_r[g] <= cmd_data;
					end
				end
			end
		end
	endgenerate

	// Repeat count: reset gives one, recall restores the saved copy.
	always_comb begin
		rpt_nxt = rpt_r;
		inf_nxt = inf_r;
		if (cmd_take) begin
			case (cmd_code)
				CMD_COUNT: begin
					rpt_nxt = cmd_data[COUNT_W-1:0];
					inf_nxt = cmd_inf;
				end
				CMD_RESET: begin
					rpt_nxt = REPEAT_RESET;
					inf_nxt = 1'b0;
				end
				CMD_RECALL: begin
					rpt_nxt = rpt_saved_r;
					inf_nxt = inf_saved_r;
				end
				default: begin
					rpt_nxt = rpt_r;
				end
			endcase
		end
	end

	// Lengths and saved setup are registered here.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			vlen_r      <= LEN_RESET;
			ilen_r      <= LEN_RESET;
			dlen_r      <= LEN_RESET;
			rpt_r       <= REPEAT_RESET;
			inf_r       <= 1'b0;
			rpt_saved_r <= REPEAT_RESET;
			inf_saved_r <= 1'b0;
		end else begin
			rpt_r <= rpt_nxt;
			inf_r <= inf_nxt;
			if (cmd_take && cmd_code == CMD_LIST_V) begin
				vlen_r <= cmd_len;
			end
			if (cmd_take && cmd_code == CMD_LIST_I) begin
				ilen_r <= cmd_len;
			end
			if (cmd_take && cmd_code == CMD_LIST_DW) begin
				dlen_r <= cmd_len;
			end
			if (cmd_take && cmd_code == CMD_SAVE) begin
				rpt_saved_r <= rpt_r;
				inf_saved_r <= inf_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trigger logic and point sequencing.
	////////////////////////////////////////////////////////////////////////////

	trig_state_t            st_r;       // Trigger state.
	trig_state_t            st_nxt;
	logic [POINT_IDX_W-1:0] idx_r;      // Next point to execute.
	logic [POINT_IDX_W-1:0] idx_nxt;
	logic [POINT_IDX_W-1:0] cur_r;      // Point on the output now.
	logic [POINT_IDX_W-1:0] cur_nxt;
	logic [COUNT_W-1:0]     pass_r;     // Passes finished so far.
	logic [COUNT_W-1:0]     pass_nxt;
	logic                   done_nxt;   // Sequence done pulse.
	logic                   ovr_v_r;    // Voltage overridden this interval.
	logic                   ovr_v_nxt;
	logic                   ovr_i_r;    // Current overridden this interval.
	logic                   ovr_i_nxt;
	logic [POINT_IDX_W-1:0] seq_len;    // Effective list length.
	logic                   abort_cmd;  // Explicit or implied abort.
	logic                   trig_in;    // Any trigger event.
	logic                   imm_trig;   // Immediate trigger command.
	logic                   pass_end;   // The point just dwelt was last.
	logic                   live_r;     // A run has put a point on the output.
	logic                   live_nxt;

	dwell_if dw ();

	dwell_timer u_timer (
		.sys_clk (sys_clk),
		.reset   (reset),
		.dw      (dw.timer)
	);

	// The longer of the voltage and current lists sets the length; a single-entry list stretches to match.
	assign seq_len = (vlen_r > ilen_r) ? vlen_r : ilen_r;

	assign abort_cmd = cmd_take && (cmd_code == CMD_ABORT || cmd_code == CMD_RESET ||
		cmd_code == CMD_RECALL || cmd_code == CMD_LIST_V || cmd_code == CMD_LIST_I ||
		cmd_code == CMD_LIST_DW || cmd_code == CMD_COUNT);
	assign imm_trig  = cmd_take && cmd_code == CMD_TRIGGER;
	assign trig_in   = ext_trigger || imm_trig;
	assign pass_end  = (cur_r == seq_len - POINT_IDX_W'(1));

	// Load the new point's dwell on entry to the change state; idx_r is the point
	// being entered there, while cur_r still names the one just finished.
	assign dw.load  = (st_r == TS_CHANGE);
	assign dw.value = dpt_r[pick(dlen_r, idx_r)];
	assign dw.stop  = abort_cmd;

	// Next state and point bookkeeping.
	always_comb begin
		st_nxt    = st_r;
		idx_nxt   = idx_r;
		cur_nxt   = cur_r;
		pass_nxt  = pass_r;
		done_nxt  = 1'b0;
		ovr_v_nxt = ovr_v_r;
		ovr_i_nxt = ovr_i_r;
		live_nxt  = live_r;
		if (cmd_take && cmd_code == CMD_LEVEL_V) begin
			ovr_v_nxt = 1'b1;
		end
		if (cmd_take && cmd_code == CMD_LEVEL_I) begin
			ovr_i_nxt = 1'b1;
		end
		if (abort_cmd) begin
			st_nxt   = TS_IDLE;
			idx_nxt  = '0;
			pass_nxt = '0;
			live_nxt = 1'b0;
		end else begin
			case (st_r)
				TS_IDLE: begin
					// Triggers do nothing until armed.
					if (cmd_take && cmd_code == CMD_INIT) begin
						st_nxt = TS_ARMED;
					end
				end
				TS_ARMED: begin
					if (trig_in) begin
						st_nxt = TS_CHANGE;
					end
				end
				TS_CHANGE: begin
					// Move to the stored point in order; overrides end here.
					cur_nxt   = idx_r;
					idx_nxt   = (idx_r == seq_len - POINT_IDX_W'(1)) ? '0 : idx_r + POINT_IDX_W'(1);
					ovr_v_nxt = 1'b0;
					ovr_i_nxt = 1'b0;
					live_nxt  = 1'b1;
					st_nxt    = TS_DWELL;
				end
				TS_DWELL: begin
					// Triggers are ignored here.
					if (dw.expire) begin
						if (pass_end) begin
							done_nxt = 1'b1;
							pass_nxt = pass_r + COUNT_W'(1);
						end
						if (pass_end && !inf_r && pass_r + COUNT_W'(1) >= rpt_r) begin
							st_nxt   = TS_IDLE;
							pass_nxt = '0;
						end else if (step_once) begin
							st_nxt = TS_ARMED;
						end else begin
							st_nxt = TS_CHANGE;
						end
					end
				end
				default: begin
					st_nxt = TS_IDLE;
				end
			endcase
		end
	end

	// Registers only.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_r                <= TS_IDLE;
			idx_r               <= '0;
			cur_r               <= '0;
			pass_r              <= '0;
			sequence_done_event <= 1'b0;
			ovr_v_r             <= 1'b0;
			ovr_i_r             <= 1'b0;
			live_r              <= 1'b0;
		end else begin
			st_r                <= st_nxt;
			idx_r               <= idx_nxt;
			cur_r               <= cur_nxt;
			pass_r              <= pass_nxt;
			sequence_done_event <= done_nxt;
			ovr_v_r             <= ovr_v_nxt;
			ovr_i_r             <= ovr_i_nxt;
			live_r              <= live_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output levels.
	////////////////////////////////////////////////////////////////////////////

	// The list drives a quantity only in list mode, after a first trigger,
	// and when no immediate level has overridden this interval.
	// Between single steps the last executed point stays on the output.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			volt_out <= '0;
			curr_out <= '0;
		end else begin
			volt_out <= (volt_list_mode && live_r && !ovr_v_nxt) ?
				vpt_r[pick(vlen_r, cur_r)] : volt_fixed;
			curr_out <= (curr_list_mode && live_r && !ovr_i_nxt) ?
				ipt_r[pick(ilen_r, cur_r)] : curr_fixed;
		end
	end

	assign dwelling_flag = (st_r == TS_DWELL);
	assign repeat_count  = rpt_r;
	assign repeat_inf    = inf_r;

	////////////////////////////////////////////////////////////////////////////
	// Completion signalling.
	////////////////////////////////////////////////////////////////////////////

	logic all_done;     // No pending operation anywhere.
	logic wait_r;       // Holding commands after a wait.
	logic wait_nxt;
	logic opc_arm_r;    // Completion command seen.
	logic opc_arm_nxt;
	logic opq_arm_r;    // Completion query seen.
	logic opq_arm_nxt;
	logic opc_st_nxt;

	assign all_done = (st_r == TS_IDLE) && !other_pending;

	// Commands keep flowing while the sequence runs, except behind a wait.
	assign cmd_ready = !wait_r;

	// Arm on command, fire once everything is done; a new arm wins over firing, except a query, which fires and re-arms.
	always_comb begin
		wait_nxt    = wait_r;
		opc_arm_nxt = opc_arm_r;
		opq_arm_nxt = opq_arm_r;
		opc_st_nxt  = opc_status;
		if (wait_r && all_done) begin
			wait_nxt = 1'b0;
		end
		if (opc_arm_r && all_done) begin
			opc_arm_nxt = 1'b0;
			opc_st_nxt  = 1'b1;
		end
		if (opq_arm_r && all_done) begin
			opq_arm_nxt = 1'b0;
		end
		if (cmd_take) begin
			case (cmd_code)
				CMD_WAIT:  wait_nxt = 1'b1;
				CMD_OPC:   begin
					opc_arm_nxt = 1'b1;
					opc_st_nxt  = 1'b0;
				end
				CMD_OPC_Q: opq_arm_nxt = 1'b1;
				CMD_RESET: opc_st_nxt = 1'b0;
				default:   wait_nxt = wait_nxt;
			endcase
		end
	end

	// Registers only; the query answer is a one-cycle pulse carrying 1.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wait_r          <= 1'b0;
			opc_arm_r       <= 1'b0;
			opq_arm_r       <= 1'b0;
			opc_status      <= 1'b0;
			opc_query_valid <= 1'b0;
			opc_query_data  <= 8'h00;
		end else begin
			wait_r          <= wait_nxt;
			opc_arm_r       <= opc_arm_nxt;
			opq_arm_r       <= opq_arm_nxt;
			opc_status      <= opc_st_nxt;
			opc_query_valid <= opq_arm_r && all_done;
			opc_query_data  <= (opq_arm_r && all_done) ? 8'h01 : 8'h00;
		end
	end
endmodule // output_list_sequencer

// ===== output_list_sequencer_bench.sv
`timescale 1ns/1ps
// Self-checking bench with a queue model of the point list.
module output_list_sequencer_bench;
	import list_seq_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic cmd_valid, cmd_ready, cmd_inf, ext_trigger, other_pending;
	logic [3:0] cmd_code;
	logic [4:0] cmd_index, cmd_len;
	logic [31:0] cmd_data;
	logic volt_list_mode = 1'b1, curr_list_mode = 1'b1, step_once = 1'b0;
	logic [15:0] volt_fixed, curr_fixed, volt_out, curr_out, repeat_count;
	logic dwelling_flag, sequence_done_event, opc_status, opc_query_valid, repeat_inf;
	logic [7:0] opc_query_data;
	int errors = 0, checked = 0, cycles = 0, dones = 0, qv = 0, seed = 32'h32b02892;
	int vq[$];   // Model of the programmed voltage points.
	int ci, w, j;
	cmd_t ab[7] = '{CMD_ABORT, CMD_RESET, CMD_RECALL, CMD_LIST_V, CMD_LIST_I,
		CMD_LIST_DW, CMD_COUNT};
	always #2.5 sys_clk = ~sys_clk;
	initial begin
		ext_trigger = 1'b0;
		other_pending = 1'b0;
		volt_fixed = 16'h1234;
		curr_fixed = 16'h0ABC;
	end
	list_cmd_host host_u (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_index(cmd_index), .cmd_data(cmd_data),
		.cmd_len(cmd_len), .cmd_inf(cmd_inf));
	output_list_sequencer dut_u (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_index(cmd_index),
		.cmd_data(cmd_data), .cmd_len(cmd_len), .cmd_inf(cmd_inf),
		.volt_list_mode(volt_list_mode), .curr_list_mode(curr_list_mode),
		.step_once(step_once), .ext_trigger(ext_trigger), .other_pending(other_pending),
		.volt_fixed(volt_fixed), .curr_fixed(curr_fixed), .volt_out(volt_out),
		.curr_out(curr_out), .dwelling_flag(dwelling_flag),
		.sequence_done_event(sequence_done_event), .opc_status(opc_status),
		.opc_query_valid(opc_query_valid), .opc_query_data(opc_query_data),
		.repeat_count(repeat_count), .repeat_inf(repeat_inf));
	////////////////////////////////////////
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", checked, errors);
			if (errors == 0 && checked > 0) begin
				$display("No errors found");
			end else begin
				$display("Errors were found");
			end
			$finish;
		end
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		begin
			checked++;
			if (seen !== exp) begin
				errors++;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Bounded wait for the dwelling flag; returns the cycles spent.
	task wait_lvl(input logic v, output int i);
		begin
			i = 0;
			while (dwelling_flag !== v && i < 2000) begin
				@(posedge sys_clk);
				i++;
			end
			check(dwelling_flag, v);
		end
	endtask
	task pulse;
		begin
			ext_trigger <= 1'b1;
			@(posedge sys_clk);
			ext_trigger <= 1'b0;
		end
	endtask
	// Random voltage list, one current point, one dwell of two ticks.
	task load(input int n, input logic [15:0] cnt, input logic inf);
		int k;
		begin
			vq.delete();
			for (k = 0; k < n; k++) begin
				vq.push_back($random(seed) & 16'hFFFF);
				host_u.send(CMD_LIST_V, k[4:0], 32'(vq[k]), n[4:0], 1'b0);
			end
			ci = $random(seed) & 16'hFFFF;
			host_u.send(CMD_LIST_I, 5'h00, 32'(ci), 5'h01, 1'b0);
			host_u.send(CMD_LIST_DW, 5'h00, 32'h00000002, 5'h01, 1'b0);
			host_u.send(CMD_COUNT, 5'h00, {16'h0000, cnt}, 5'h00, inf);
		end
	endtask
	// Walk the points; point k dwells k + 1 ticks, seen here one cycle short.
	task run_points(input int n, input int passes);
		int p;
		begin
			for (p = 0; p < n * passes; p++) begin
				wait_lvl(1'b1, w);
				cyc(3);
				check(volt_out, 32'(vq[p % n]));
				check(curr_out, 32'(ci));
				wait_lvl(1'b0, w);
				check(32'(w >= TICK_CYCLES * (p % n + 1) - 3 &&
					w <= TICK_CYCLES * (p % n + 1) + 1), 1);
			end
		end
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (sequence_done_event === 1'b1) dones++;
		if (opc_query_valid === 1'b1) begin
			qv++;
			check(opc_query_data, 8'h01);
		end
		if (cycles == 60000) begin
			errors++;
			give_verdict;
		end
	end
	////////////////////////////////////////
	initial begin
		cyc(8);
		reset <= 1'b0;
		cyc(1);
		check({repeat_count, 7'h00, repeat_inf, 7'h00, cmd_ready}, 32'h00010001);
		check(dwelling_flag, 0);
		$display("test reset done");
		load(3, 16'h0002, 1'b0);
		for (j = 0; j < 3; j++) host_u.send(CMD_LIST_DW, j[4:0], 32'(j + 1), 5'h03, 1'b0);
		check(repeat_count, 2);
		dones = 0;
		host_u.send(CMD_INIT, 5'h00, 32'h0, 5'h01, 1'b0);
		cyc(50);
		check(dwelling_flag, 0);
		host_u.send(CMD_TRIGGER, 5'h00, 32'h0, 5'h01, 1'b0);
		run_points(3, 2);
		cyc(20);
		check(32'(dones), 2);
		check(dwelling_flag, 0);
		$display("test auto done");
		curr_list_mode <= 1'b0;
		step_once <= 1'b1;
		load(2, 16'h0001, 1'b0);
		host_u.send(CMD_INIT, 5'h00, 32'h0, 5'h01, 1'b0);
		pulse;
		wait_lvl(1'b1, w);
		cyc(3);
		check(volt_out, 32'(vq[0]));
		check(curr_out, curr_fixed);
		pulse;
		wait_lvl(1'b0, w);
		check(32'(w >= 2 * TICK_CYCLES - 3 && w <= 2 * TICK_CYCLES + 1), 1);
		cyc(50);
		check(dwelling_flag, 0);
		check(volt_out, 32'(vq[0]));
		host_u.send(CMD_TRIGGER, 5'h00, 32'h0, 5'h01, 1'b0);
		wait_lvl(1'b1, w);
		cyc(3);
		check(volt_out, 32'(vq[1]));
		host_u.send(CMD_LEVEL_V, 5'h00, 32'h0, 5'h01, 1'b0);
		check(volt_out, volt_fixed);
		wait_lvl(1'b0, w);
		$display("test single step done");
		curr_list_mode <= 1'b1;
		step_once <= 1'b0;
		load(2, 16'h0001, 1'b0);
		host_u.send(CMD_INIT, 5'h00, 32'h0, 5'h01, 1'b0);
		host_u.send(CMD_TRIGGER, 5'h00, 32'h0, 5'h01, 1'b0);
		wait_lvl(1'b1, w);
		cyc(3);
		check(volt_out, 32'(vq[0]));
		qv = 0;
		host_u.send(CMD_OPC_Q, 5'h00, 32'h0, 5'h01, 1'b0);
		cyc(20);
		check(32'(qv), 0);
		other_pending <= 1'b1;
		host_u.send(CMD_OPC, 5'h00, 32'h0, 5'h01, 1'b0);
		host_u.send(CMD_WAIT, 5'h00, 32'h0, 5'h01, 1'b0);
		check(cmd_ready, 0);
		cyc(1000);
		check({cmd_ready, opc_status, dwelling_flag}, 0);
		check(32'(qv), 0);
		other_pending <= 1'b0;
		cyc(10);
		check({cmd_ready, opc_status}, 3);
		check(32'(qv), 1);
		$display("test completion done");
		load(2, 16'h0003, 1'b0);
		host_u.send(CMD_SAVE, 5'h00, 32'h0, 5'h01, 1'b0);
		for (j = 0; j < 7; j++) begin
			load(2, 16'h0000, 1'b1);
			host_u.send(CMD_INIT, 5'h00, 32'h0, 5'h01, 1'b0);
			host_u.send(CMD_TRIGGER, 5'h00, 32'h0, 5'h01, 1'b0);
			wait_lvl(1'b1, w);
			check(repeat_inf, 1);
			host_u.send(ab[j], 5'h00, 32'h0, 5'h01, 1'b0);
			check(dwelling_flag, 0);
			if (ab[j] == CMD_RESET) check({repeat_count, repeat_inf}, 32'h2);
			if (ab[j] == CMD_RECALL) check({repeat_count, repeat_inf}, 32'h6);
		end
		$display("test abort done");
		give_verdict;
	end
endmodule // output_list_sequencer_bench

// ===== output_list_sequencer_monitor.sv
`timescale 1ns/1ps
// Port-level checks on the list sequencer.
module output_list_sequencer_monitor
	import list_seq_pkg::*;
(
	input wire logic               sys_clk,
	input wire logic               reset,
	input wire logic               cmd_valid,
	input wire logic               cmd_ready,
	input wire logic [3:0]         cmd_code,
	input wire logic               ext_trigger,
	input wire logic               other_pending,
	input wire logic               dwelling_flag,
	input wire logic               sequence_done_event,
	input wire logic               opc_query_valid,
	input wire logic [7:0]         opc_query_data,
	input wire logic [COUNT_W-1:0] repeat_count,
	input wire logic               repeat_inf
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	logic take;        // A command is taken this cycle.
	logic trig_seen_r; // A trigger has arrived since the last abort.
	logic trig_seen_nxt;
	assign take = cmd_valid && cmd_ready;
	// An abort clears the flag; a trigger wins so the check stays safe.
	always_comb begin
		trig_seen_nxt = trig_seen_r;
		if (take && cmd_code inside {4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA}) begin
			trig_seen_nxt = 1'b0;
		end
		if (ext_trigger || (take && cmd_code == CMD_TRIGGER)) begin
			trig_seen_nxt = 1'b1;
		end
		if (reset) begin
			trig_seen_nxt = 1'b0;
		end
	end
	// Registers only.
	always_ff @(posedge sys_clk) begin
		trig_seen_r <= trig_seen_nxt;
	end
	////////////////////////////////////////
	a_no_dwell_untriggered: assert property (dwelling_flag |-> trig_seen_r)
		else $error("dwelling without a trigger");
	a_done_one_cycle: assert property (sequence_done_event |=> !sequence_done_event)
		else $error("sequence done longer than one cycle");
	a_done_after_dwell: assert property (sequence_done_event |->
		$past(dwelling_flag) || $past(dwelling_flag, 2) || $past(dwelling_flag, 3))
		else $error("sequence done without a dwell end");
	a_abort_ends_dwell: assert property (take && cmd_code == CMD_ABORT |=> !dwelling_flag)
		else $error("abort left dwelling state");
	a_wait_holds_off: assert property (take && cmd_code == CMD_WAIT && dwelling_flag
		|=> !cmd_ready)
		else $error("wait did not hold commands");
	a_wait_pending: assert property (!cmd_ready && other_pending |=> !cmd_ready)
		else $error("wait released while others pending");
	a_query_value: assert property (opc_query_valid |-> opc_query_data == 8'h01)
		else $error("completion query value wrong");
	a_query_idle: assert property (opc_query_valid |->
		$past(!dwelling_flag) && $past(!other_pending))
		else $error("completion query while busy");
	a_count_reset: assert property ($past(reset) |-> repeat_count == 16'h0001 && !repeat_inf)
		else $error("repeat count not one after reset");
	c_done: cover property (sequence_done_event);
	c_query: cover property (opc_query_valid);
	c_trig_dwell: cover property (dwelling_flag && ext_trigger);
endmodule // output_list_sequencer_monitor

bind output_list_sequencer output_list_sequencer_monitor mon_u (.sys_clk(sys_clk),
	.reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
	.ext_trigger(ext_trigger), .other_pending(other_pending), .dwelling_flag(dwelling_flag),
	.sequence_done_event(sequence_done_event), .opc_query_valid(opc_query_valid),
	.opc_query_data(opc_query_data), .repeat_count(repeat_count), .repeat_inf(repeat_inf));
